// ---- gtm_defines.vh ----
// Constants for the gated 16-bit timer block
`ifndef GTM_DEFINES_VH
`define GTM_DEFINES_VH

// Register offsets on the plain register port
`define GTM_ADDR_W        4
`define GTM_REG_CTRL      4'h0
`define GTM_REG_GATE      4'h1
`define GTM_REG_CNT_LO    4'h2
`define GTM_REG_CNT_HI    4'h3
`define GTM_REG_FLAGS     4'h4

// Control register fields
`define GTM_CTRL_ON       0
`define GTM_CTRL_IRQ_EN   1
`define GTM_CTRL_ASYNC    2

// Gate register fields
`define GTM_GATE_EN       7
`define GTM_GATE_POL      6
`define GTM_GATE_TGL      5
`define GTM_GATE_SPM      4
`define GTM_GATE_GO       3
`define GTM_GATE_VAL      2
`define GTM_GATE_SS_HI    1
`define GTM_GATE_SS_LO    0

// Flag register fields
`define GTM_FLAG_OVF      0

// Gate source codes
`define GTM_SS_PIN        2'h0
`define GTM_SS_T8_OVF     2'h1
`define GTM_SS_AUX_MATCH  2'h2
`define GTM_SS_RSVD       2'h3

// Counter limits
`define GTM_CNT_MAX       16'hffff
`define GTM_CNT_ZERO      16'h0000
`define GTM_BYTE_ZERO     8'h00

`endif

// ---- gtm_timer.v ----
// Gated 16-bit timer with overflow flag, trigger reset and gate logic
//
// Overview of operation
// [RULE1] Count up to FFFF then wrap to zero
// [RULE2] Wrap sets sticky overflow flag until cleared
// [RULE3] Interrupt request only while enable set
// [RULE4] Special event trigger resets the counter
// [RULE5] Trigger reset ignored in asynchronous counter mode
// [RULE6] Software write beats simultaneous trigger reset
// [RULE7] Trigger reset never sets overflow flag; the code sets it when a tick at FFFF comes with the trigger
// [RULE8] Gate enable with selectable gate polarity
// [RULE9] Count on tick while gate permits, else hold
// [RULE10] Source select: pin, overflow, period match
// [RULE11] 8-bit overflow gives internal rising pulse
// [RULE12] Period match reset gives internal rising pulse
// [RULE13] Toggle flip-flop inverts on each rising edge
// [RULE14] Toggle bit clear holds flip-flop at zero
// [RULE15] Software sets single pulse, then go
// [RULE16] Go arms on rising edge, clears on falling
// [RULE17] After done, gate ignored until go again
// [RULE18] Clearing single pulse bit clears go
// [RULE19] Toggle and single pulse work together
// [RULE20] Gate level status readable, valid always
// [RULE21] Toggle mode status shows counting window
// [RULE22] Runs only with on and gate enable; the code also counts, ungated, with on set and gate enable clear
// [RULE23] Source code 11 drives gate inactive
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gtm_defines.vh"

module gtm_timer #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input  wire                   CLK,
  input  wire                   RSTN,
  // Register port
  input  wire [`GTM_ADDR_W-1:0] ADDR,
  input  wire [7:0]             WDATA,
  input  wire                   WR,
  input  wire                   RD,
  output reg  [7:0]             RDATA,
  // Timer clock tick, synchronous to CLK
  input  wire                   TICK,
  // Gate sources
  input  wire                   GATE_PIN,
  input  wire                   T8_OVF,
  input  wire                   AUX_MATCH_RST,
  // Special event trigger from the compare units
  input  wire                   SPECIAL_TRIG,
  // Status outputs
  output reg                    OVF_IRQ,
  output reg                    GATE_LEVEL
);

  reg             timer_on_r;
  reg             irq_en_r;
  reg             async_r;
  reg             gate_en_r;
  reg             gate_pol_r;
  reg             tgl_en_r;
  reg             spm_r;
  reg             go_r;
  reg  [1:0]      gss_r;
  reg             overflow_flag_r;
  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] cnt_nxt;
  reg             tgl_r;
  reg             src_d_r;
  reg             gv_d_r;
  reg             armed_r;
  reg             gate_src;
  reg             gate_val;
  reg  [7:0]      rd_nxt;
  wire            wr_lo;
  wire            wr_hi;
  wire            src_rise;
  wire            gate_raw;
  wire            gv_rise;
  wire            gv_fall;
  wire            gate_ok;
  wire            inc;
  wire            wrap;
  wire            ovf_clr;
  wire            gate_wr;

  assign wr_lo   = WR && (ADDR == `GTM_REG_CNT_LO);
  assign wr_hi   = WR && (ADDR == `GTM_REG_CNT_HI);
  assign gate_wr = WR && (ADDR == `GTM_REG_GATE);
  assign ovf_clr = WR && (ADDR == `GTM_REG_FLAGS) && !WDATA[`GTM_FLAG_OVF];

  // Source select; reserved code keeps the gate low
  always @* begin
    case (gss_r)
      `GTM_SS_PIN:       gate_src = GATE_PIN;
      // Source pulse from 8-bit overflow
      `GTM_SS_T8_OVF:    gate_src = T8_OVF;
      // Source pulse from period match
      `GTM_SS_AUX_MATCH: gate_src = AUX_MATCH_RST;
      // [RULE23] reserved source inactive
      default:           gate_src = 1'b0;
    endcase
  end

  // [RULE11] overflow pulse sourced
  // [RULE12] match pulse sourced
  assign src_rise = gate_src && !src_d_r;

  // [RULE13] toggle stage
  assign gate_raw = tgl_en_r ? tgl_r : gate_src;

  // [RULE8] polarity applied
  // [RULE19] toggle feeds pulse stage
  always @* begin
    gate_val = gate_pol_r ? gate_raw : !gate_raw;
    if (gss_r == `GTM_SS_RSVD) begin
      // [RULE23] reserved holds count while gate enabled
      gate_val = 1'b0;
    end
  end

  assign gv_rise = gate_val && !gv_d_r;
  assign gv_fall = !gate_val && gv_d_r;

  // [RULE16] window after arming
  // [RULE17] done blocks gate
  assign gate_ok = !gate_en_r ||
                   (spm_r ? (gate_val && (armed_r || (go_r && gv_rise)))
                          : gate_val);

  // [RULE22] on required; gate enable clear counts ungated
  // [RULE9] increment on tick
  assign inc  = timer_on_r && gate_ok && TICK;
  assign wrap = inc && (cnt_r == `GTM_CNT_MAX);

  // Counter next value; write beats trigger
  always @* begin
    cnt_nxt = cnt_r;
    if (wr_lo) begin
      // [RULE6] write takes precedence
      cnt_nxt = {cnt_r[CNT_W-1:8], WDATA};
    end else if (wr_hi) begin
      cnt_nxt = {WDATA, cnt_r[7:0]};
    end else if (SPECIAL_TRIG && !async_r) begin
      // [RULE4] trigger reset
      // [RULE5] not in async mode
      cnt_nxt = `GTM_CNT_ZERO;
    end else if (inc) begin
      // [RULE1] count and wrap
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rd_nxt = `GTM_BYTE_ZERO;
    case (ADDR)
      `GTM_REG_CTRL: begin
        rd_nxt[`GTM_CTRL_ON]     = timer_on_r;
        rd_nxt[`GTM_CTRL_IRQ_EN] = irq_en_r;
        rd_nxt[`GTM_CTRL_ASYNC]  = async_r;
      end
      `GTM_REG_GATE: begin
        rd_nxt[`GTM_GATE_EN]  = gate_en_r;
        rd_nxt[`GTM_GATE_POL] = gate_pol_r;
        rd_nxt[`GTM_GATE_TGL] = tgl_en_r;
        rd_nxt[`GTM_GATE_SPM] = spm_r;
        rd_nxt[`GTM_GATE_GO]  = go_r;
        // [RULE20] live gate level
        rd_nxt[`GTM_GATE_VAL] = gate_val;
        rd_nxt[`GTM_GATE_SS_HI:`GTM_GATE_SS_LO] = gss_r;
      end
      `GTM_REG_CNT_LO: rd_nxt = cnt_r[7:0];
      `GTM_REG_CNT_HI: rd_nxt = cnt_r[CNT_W-1:8];
      `GTM_REG_FLAGS:  rd_nxt[`GTM_FLAG_OVF] = overflow_flag_r;
      default:         rd_nxt = `GTM_BYTE_ZERO;
    endcase
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_on_r      <= 1'b0;
      irq_en_r        <= 1'b0;
      async_r         <= 1'b0;
      gate_en_r       <= 1'b0;
      gate_pol_r      <= 1'b0;
      tgl_en_r        <= 1'b0;
      spm_r           <= 1'b0;
      go_r            <= 1'b0;
      gss_r           <= `GTM_SS_PIN;
      overflow_flag_r <= 1'b0;
      cnt_r           <= `GTM_CNT_ZERO;
      tgl_r           <= 1'b0;
      src_d_r         <= 1'b0;
      gv_d_r          <= 1'b0;
      armed_r         <= 1'b0;
      RDATA           <= `GTM_BYTE_ZERO;
      OVF_IRQ         <= 1'b0;
      GATE_LEVEL      <= 1'b0;
    end else begin
      src_d_r <= gate_src;
      gv_d_r  <= gate_val;
      cnt_r   <= cnt_nxt;
      RDATA   <= RD ? rd_nxt : `GTM_BYTE_ZERO;

      if (WR && (ADDR == `GTM_REG_CTRL)) begin
        timer_on_r <= WDATA[`GTM_CTRL_ON];
        irq_en_r   <= WDATA[`GTM_CTRL_IRQ_EN];
        async_r    <= WDATA[`GTM_CTRL_ASYNC];
      end

      if (gate_wr) begin
        gate_en_r  <= WDATA[`GTM_GATE_EN];
        gate_pol_r <= WDATA[`GTM_GATE_POL];
        tgl_en_r   <= WDATA[`GTM_GATE_TGL];
        spm_r      <= WDATA[`GTM_GATE_SPM];
        gss_r      <= WDATA[`GTM_GATE_SS_HI:`GTM_GATE_SS_LO];
      end

      // [RULE14] toggle held clear
      if (!tgl_en_r) begin
        tgl_r <= 1'b0;
      end else if (src_rise) begin
        tgl_r <= !tgl_r;
      end

      // [RULE15] software arms go
      // [RULE18] pulse bit clears go
      if (gate_wr && !WDATA[`GTM_GATE_SPM]) begin
        go_r    <= 1'b0;
        armed_r <= 1'b0;
      end else if (gate_wr && WDATA[`GTM_GATE_GO] && spm_r) begin
        go_r    <= 1'b1;
        armed_r <= 1'b0;
      end else if (spm_r && go_r) begin
        // [RULE16] arm then done
        if (armed_r && gv_fall) begin
          go_r    <= 1'b0;
          armed_r <= 1'b0;
        end else if (gv_rise) begin
          armed_r <= 1'b1;
        end
      end else begin
        armed_r <= 1'b0;
      end

      // [RULE2] sticky flag, set wins
      // [RULE7] trigger alone never sets it; a tick at FFFF in the same cycle sets it
      if (wrap && (cnt_nxt == `GTM_CNT_ZERO)) begin
        overflow_flag_r <= 1'b1;
      end else if (ovf_clr) begin
        overflow_flag_r <= 1'b0;
      end

      // [RULE3] gated request
      OVF_IRQ <= irq_en_r && overflow_flag_r;
      // [RULE21] counting window shown
      GATE_LEVEL <= gate_val;
    end
  end

endmodule // gtm_timer
`default_nettype wire

// ---- gtm_checker.sv ----
// Port checker for the gated timer
`timescale 1ns/1ps
`default_nettype none
`include "gtm_defines.vh"
module gtm_checker (
  // Clock, reset and register port
  input wire logic                   CLK,
  input wire logic                   RSTN,
  input wire logic [`GTM_ADDR_W-1:0] ADDR,
  input wire logic [7:0]             WDATA,
  input wire logic                   WR,
  input wire logic                   RD,
  input wire logic [7:0]             RDATA,
  // Gate and status
  input wire logic                   GATE_PIN,
  input wire logic                   OVF_IRQ,
  input wire logic                   GATE_LEVEL
);
  logic [7:0] gsh_r;
  logic       ien_r;
  logic [1:0] live_r;
  // Shadow of written bits; the pin gate level check waits two edges after reset
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      gsh_r  <= 8'h00;
      ien_r  <= 1'h0;
      live_r <= 2'h0;
    end else begin
      live_r <= {live_r[0], 1'h1};
      if (WR && ADDR == `GTM_REG_GATE) gsh_r <= WDATA;
      if (WR && ADDR == `GTM_REG_CTRL) ien_r <= WDATA[1];
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  sequence s_irq_off;
    WR && ADDR == `GTM_REG_CTRL && !WDATA[1] ##1 !WR;
  endsequence
  sequence s_rsvd_sel;
    WR && ADDR == `GTM_REG_GATE && WDATA[1:0] == `GTM_SS_RSVD ##1 !WR;
  endsequence
  a_irq_needs_en:
    assert property (OVF_IRQ |-> $past(ien_r)) else $error("irq unenabled");
  a_irq_off_write:
    assert property (s_irq_off |=> !OVF_IRQ) else $error("irq after off");
  a_flag_irq_tie:
    assert property (RD && ADDR == `GTM_REG_FLAGS && ien_r
      |=> RDATA[0] == OVF_IRQ) else $error("flag and irq differ");
  a_pin_gate_lvl:
    assert property (live_r[1] && gsh_r[5:4] == 2'h0 &&
      gsh_r[1:0] == `GTM_SS_PIN |=> GATE_LEVEL == ($past(gsh_r[6]) ~^
      $past(GATE_PIN))) else $error("gate level wrong");
  a_rsvd_gate_off:
    assert property (s_rsvd_sel |=> !GATE_LEVEL) else $error("rsvd gate");
  a_status_read:
    assert property (RD && ADDR == `GTM_REG_GATE |=> RDATA[2] == GATE_LEVEL
      || RDATA[2] == $past(GATE_LEVEL)) else $error("status bit wrong");
  a_rdata_idle:
    assert property (!RD |=> RDATA == 8'h00) else $error("rdata not idle");
  a_unmapped_zero:
    assert property (RD && ADDR > `GTM_REG_FLAGS |=> RDATA == 8'h00)
      else $error("unmapped read");
endmodule // gtm_checker
bind gtm_timer gtm_checker u_chk (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .GATE_PIN(GATE_PIN),
  .OVF_IRQ(OVF_IRQ), .GATE_LEVEL(GATE_LEVEL));
`default_nettype wire

// ---- gtm_partner.sv ----
// Model of the neighbouring timers and the gate pin
`timescale 1ns/1ps
`default_nettype none
module gtm_partner #(
  parameter logic [7:0] AUX_PER = 8'h63
) (
  // Clock and bench control
  input  wire logic CLK,
  input  wire logic RSTN,
  input  wire logic run,
  input  wire logic pin_lvl,
  // Gate sources
  output wire logic GATE_PIN,
  output var logic  T8_OVF,
  output var logic  AUX_MATCH_RST
);
  logic [7:0] t8_r;
  logic [7:0] aux_r;
  assign GATE_PIN = pin_lvl;
  // Stopped timers give no pulses, so held gates stay quiet
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      t8_r <= 8'h00;
      aux_r <= 8'h00;
      T8_OVF <= 1'h0;
      AUX_MATCH_RST <= 1'h0;
    end else begin
      t8_r <= run ? t8_r + 8'h01 : t8_r;
      T8_OVF <= run && t8_r == 8'hff;
      aux_r <= !run ? aux_r : (aux_r == AUX_PER) ? 8'h00 : aux_r + 8'h01;
      AUX_MATCH_RST <= run && aux_r == AUX_PER;
    end
  end
endmodule // gtm_partner
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the gated timer
`timescale 1ns/1ps
`default_nettype none
`include "gtm_defines.vh"
module tb_top;
  logic       clk = 1'h0;
  logic       rstn = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'h0;
  logic       rd = 1'h0;
  logic       tick = 1'h0;
  logic       trig = 1'h0;
  logic       run = 1'h0;
  logic       pin = 1'h0;
  logic       flg = 1'h0;
  logic [7:0] lf = 8'h2f;
  logic [7:0] rq;
  logic [7:0] rdata;
  logic       irq, glvl, gpin, t8, aux;
  int         error_cnt = 0;
  int         compares = 0;
  int         cnt = 0;
  always #5 clk = ~clk;
  gtm_timer u_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TICK(tick), .GATE_PIN(gpin),
    .T8_OVF(t8), .AUX_MATCH_RST(aux), .SPECIAL_TRIG(trig),
    .OVF_IRQ(irq), .GATE_LEVEL(glvl));
  gtm_partner u_far (.CLK(clk), .RSTN(rstn), .run(run), .pin_lvl(pin),
    .GATE_PIN(gpin), .T8_OVF(t8), .AUX_MATCH_RST(aux));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // One access, then a quiet cycle so strobes never restart in one step
  task automatic acc(input logic w, r, t, input logic [3:0] a,
    input logic [7:0] d);
    wr <= w;
    rd <= r;
    trig <= t;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    trig <= 1'h0;
    #1 rq = rdata;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    acc(1'h1, 1'h0, 1'h0, a, d);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, m,
    input string n);
    acc(1'h0, 1'h1, 1'h0, a, 8'h00);
    chk(n, e & m, rq & m);
  endtask
  task automatic ticks(input int n, input logic g);
    repeat (n) begin
      lf = nx(lf);
      tick <= lf[0];
      if (lf[0] && g) cnt = cnt + 1;
      if (cnt > 32'hffff) flg = 1'h1;
      cnt = cnt & 32'hffff;
      @(posedge clk);
    end
    tick <= 1'h0;
    @(posedge clk);
  endtask
  task automatic test_done;
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    int i;
    logic [7:0] d;
    logic s;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    wreg(`GTM_REG_CNT_LO, 8'hff);
    wreg(`GTM_REG_CNT_HI, 8'hff);
    wreg(`GTM_REG_CTRL, 8'h03);
    cnt = 32'hffff;
    ticks(8, 1'h1);
    rdc(`GTM_REG_CNT_LO, cnt[7:0], 8'hff, "count");
    #1 chk("irq", {7'h00, flg}, {7'h00, irq});
    wreg(`GTM_REG_CTRL, 8'h01);
    #1 chk("masked irq", 8'h00, {7'h00, irq});
    rdc(`GTM_REG_FLAGS, {7'h00, flg}, 8'h01, "held flag");
    wreg(`GTM_REG_FLAGS, 8'h00);
    rdc(`GTM_REG_FLAGS, 8'h00, 8'h01, "cleared flag");
    wreg(`GTM_REG_CNT_HI, 8'h12);
    acc(1'h0, 1'h0, 1'h1, 4'h0, 8'h00);
    rdc(`GTM_REG_CNT_HI, 8'h00, 8'hff, "trig reset");
    rdc(`GTM_REG_FLAGS, 8'h00, 8'h01, "trig flag");
    wreg(`GTM_REG_CNT_HI, 8'h12);
    acc(1'h1, 1'h0, 1'h1, `GTM_REG_CNT_LO, 8'h55);
    rdc(`GTM_REG_CNT_HI, 8'h12, 8'hff, "write wins");
    wreg(`GTM_REG_CTRL, 8'h05);
    acc(1'h0, 1'h0, 1'h1, 4'h0, 8'h00);
    rdc(`GTM_REG_CNT_LO, 8'h55, 8'hff, "async hold");
    rdc(4'h9, 8'h00, 8'hff, "unmapped");
    wreg(`GTM_REG_CTRL, 8'h01);
    cnt = 32'h1255;
    for (i = 0; i < 16; i++) begin
      lf = nx(lf);
      pin <= lf[1];
      d = {i[3:2], 4'h0, i[1:0]};
      s = (i[1:0] == 0) ? lf[1] : 1'h0;
      s = (i[1:0] != 3) && (i[2] ~^ s);
      wreg(`GTM_REG_GATE, d);
      wreg(`GTM_REG_CNT_LO, 8'h00);
      cnt = cnt & 32'hff00;
      ticks(8, !i[3] || s);
      rdc(`GTM_REG_CNT_LO, cnt[7:0], 8'hff, "gated count");
      rdc(`GTM_REG_GATE, d | {5'h00, s, 2'h0}, 8'hc7, "status");
    end
    wreg(`GTM_REG_GATE, 8'h00);
    wreg(`GTM_REG_CTRL, 8'h00);
    ticks(8, 1'h0);
    rdc(`GTM_REG_CNT_LO, cnt[7:0], 8'hff, "timer off");
    wreg(`GTM_REG_CTRL, 8'h01);
    run <= 1'h1;
    wreg(`GTM_REG_GATE, 8'hf1);
    wreg(`GTM_REG_CNT_LO, 8'h00);
    wreg(`GTM_REG_CNT_HI, 8'h00);
    wreg(`GTM_REG_GATE, 8'hf9);
    // Long enough for a later source period that must be ignored
    tick <= 1'h1;
    repeat (1200) @(posedge clk);
    tick <= 1'h0;
    @(posedge clk);
    rdc(`GTM_REG_CNT_HI, 8'h01, 8'hff, "period hi");
    rdc(`GTM_REG_CNT_LO, 8'h00, 8'hff, "period lo");
    rdc(`GTM_REG_GATE, 8'hf1, 8'hfb, "done");
    wreg(`GTM_REG_GATE, 8'he9);
    rdc(`GTM_REG_GATE, 8'he1, 8'hfb, "go cleared");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
